// ===== hdl/cod_pkg.sv
// Function
// RULE_01: Product of A and X, X high, A low
// RULE_02: Product opcode 42, one byte, eleven cycles
// RULE_03: Register/memory modes by high nibble, cycles, bytes
// RULE_04: Stores lack immediate, one cycle over base
// RULE_05: Jump lacks immediate, one cycle under base
// RULE_06: Absolute call lacks immediate, two cycles over
// RULE_07: Branches 20 to 2F, two bytes, three cycles
// RULE_08: 2E and 2F branch on interrupt pin level
// RULE_09: 2C and 2D branch on mask flag
// RULE_10: 28 and 29 branch on half carry
// RULE_11: Relative call AD, two bytes, six cycles
// RULE_12: Bit test branch, three bytes, bit into carry
// RULE_13: Bit set and clear, two bytes, five cycles
// RULE_14: Read/modify/write forms, lengths and cycle counts
// RULE_15: Test operation reads only, shorter cycle counts
// RULE_16: Rotates shift through carry flag
// RULE_17: Control operations one byte, two cycles
// RULE_18: Software trap 83, ten cycles, sets mask
// RULE_19: Trap return reloads flags, subroutine return six
// RULE_20: Stop and wait clear mask flag
// RULE_21: Tested flags follow result, others hold
// RULE_22: Half carry from bit 3 on add
// RULE_23: Masked interrupt stays pending until unmasked
// RULE_24: Six-bit wrapping stack, pushes two or five
// RULE_25: Unassigned opcodes act as harmless no operation
package cod_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] REG_OPCODE = 8'h00;
	localparam logic [7:0] REG_OPERAND = 8'h04;
	localparam logic [7:0] REG_ACC = 8'h08;
	localparam logic [7:0] REG_INDEX = 8'h0c;
	localparam logic [7:0] REG_FLAGS = 8'h10;
	localparam logic [7:0] REG_STACK = 8'h14;
	localparam logic [7:0] REG_RESULT = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	// Flag positions in flags_register: H I N Z C
	localparam int FL_H = 4;
	localparam int FL_I = 3;
	localparam int FL_N = 2;
	localparam int FL_Z = 1;
	localparam int FL_C = 0;
	localparam logic [4:0] FLAGS_RST = 5'h08;
	localparam logic [5:0] SP_RST = 6'h3f;
	localparam logic [5:0] PUSH_CALL = 6'h02;
	localparam logic [5:0] PUSH_IRQ = 6'h05;
	// ----------------------------------------
	// Opcodes and cycle counts
	// ----------------------------------------
	localparam logic [7:0] OPC_MUL = 8'h42;
	localparam logic [7:0] OPC_BSR = 8'had;
	localparam logic [7:0] OPC_RTI = 8'h80;
	localparam logic [7:0] OPC_RTS = 8'h81;
	localparam logic [7:0] OPC_SWI = 8'h83;
	localparam logic [7:0] OPC_STOP = 8'h8e;
	localparam logic [7:0] OPC_WAIT = 8'h8f;
	localparam logic [7:0] OPC_TAX = 8'h97;
	localparam logic [7:0] OPC_CLC = 8'h98;
	localparam logic [7:0] OPC_SEC = 8'h99;
	localparam logic [7:0] OPC_CLI = 8'h9a;
	localparam logic [7:0] OPC_SEI = 8'h9b;
	localparam logic [7:0] OPC_RSP = 8'h9c;
	localparam logic [7:0] OPC_NOP = 8'h9d;
	localparam logic [7:0] OPC_TXA = 8'h9f;
	localparam logic [3:0] CYC_MUL = 4'hb;
	localparam logic [3:0] CYC_BSR = 4'h6;
	localparam logic [3:0] CYC_RTI = 4'h9;
	localparam logic [3:0] CYC_RTS = 4'h6;
	localparam logic [3:0] CYC_SWI = 4'ha;
	localparam logic [3:0] CYC_CTL = 4'h2;
	localparam logic [3:0] CYC_BIT = 4'h5;
	localparam logic [3:0] CYC_REL = 4'h3;
	localparam logic [3:0] CYC_RMW_INH = 4'h3;
	localparam logic [3:0] CYC_RMW_MEM = 4'h5;
	localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
	localparam logic [3:0] CYC_TST_MEM = 4'h4;
	localparam logic [3:0] CYC_TST_IX1 = 4'h5;
	localparam logic [3:0] CYC_STORE_ADD = 4'h1;
	localparam logic [3:0] CYC_JUMP_SUB = 4'h1;
	localparam logic [3:0] CYC_CALL_ADD = 4'h2;
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	// Register/memory modes indexed by high nibble minus A: IMM DIR EXT IX2 IX1 IX
	localparam logic [3:0] CYC_RM [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
	localparam logic [1:0] LEN_RM [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
	typedef enum logic [2:0] {
		CL_NONE, CL_BTB, CL_BSC, CL_REL, CL_RMW, CL_MUL, CL_CTL, CL_RM
	} cod_class_type;
	typedef struct packed {
		logic illegal;
		cod_class_type cls;
		logic [1:0] len;
		logic [3:0] cyc;
	} cod_dec_type;
endpackage : cod_pkg

// ===== hdl/cod_core.sv
`timescale 1ns/100ps
module cod_core
	import cod_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic irq_line_level,
	input wire logic irq_request,
	output logic irq_ack
);
	// ----------------------------------------
	// Opcode decode
	// ----------------------------------------
	function automatic cod_dec_type decode(input logic [7:0] op);
		cod_dec_type d;
		logic [2:0] m;
		d = '{illegal: 1'b0, cls: CL_NONE, len: LEN_1, cyc: CYC_CTL};
		m = 3'(op[7:4] - 4'ha);
		case (op[7:4])
			4'h0: begin
				d.cls = CL_BTB; // RULE_12
				d.len = LEN_3;
				d.cyc = CYC_BIT;
			end
			4'h1: begin
				d.cls = CL_BSC; // RULE_13
				d.len = LEN_2;
				d.cyc = CYC_BIT;
			end
			4'h2: begin
				d.cls = CL_REL; // RULE_07
				d.len = LEN_2;
				d.cyc = CYC_REL;
			end
			4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
				if (op == OPC_MUL) begin
					d.cls = CL_MUL; // RULE_02
					d.cyc = CYC_MUL;
				end else if (op[3:0] inside {4'h1, 4'h2, 4'h5, 4'hb, 4'he}) begin
					d.illegal = 1'b1; // RULE_25
				end else begin
					d.cls = CL_RMW; // RULE_14
					case (op[7:4])
						4'h4, 4'h5: d.cyc = CYC_RMW_INH;
						4'h3: begin
							d.len = LEN_2;
							d.cyc = (op[3:0] == 4'hd) ? CYC_TST_MEM : CYC_RMW_MEM; // RULE_15
						end
						4'h7: d.cyc = (op[3:0] == 4'hd) ? CYC_TST_MEM : CYC_RMW_MEM; // RULE_15
						default: begin
							d.len = LEN_2;
							d.cyc = (op[3:0] == 4'hd) ? CYC_TST_IX1 : CYC_RMW_IX1; // RULE_15
						end
					endcase
				end
			end
			4'h8: begin
				d.cls = CL_CTL;
				case (op)
					OPC_RTI: d.cyc = CYC_RTI; // RULE_19
					OPC_RTS: d.cyc = CYC_RTS; // RULE_19
					OPC_SWI: d.cyc = CYC_SWI; // RULE_18
					OPC_STOP, OPC_WAIT: d.cyc = CYC_CTL; // RULE_20
					default: begin
						d.cls = CL_NONE;
						d.illegal = 1'b1; // RULE_25
					end
				endcase
			end
			4'h9: begin
				if (op[3:0] inside {4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf})
					d.cls = CL_CTL; // RULE_17
				else
					d.illegal = 1'b1; // RULE_25
			end
			default: begin
				if (op[7:4] == 4'ha && op[3:0] inside {4'h7, 4'hc, 4'hf}) begin
					d.illegal = 1'b1; // RULE_04 RULE_05 RULE_25
				end else if (op == OPC_BSR) begin
					d.cls = CL_RM; // RULE_11
					d.len = LEN_2;
					d.cyc = CYC_BSR;
				end else begin
					d.cls = CL_RM; // RULE_03
					d.len = LEN_RM[m];
					d.cyc = CYC_RM[m];
					case (op[3:0])
						4'h7, 4'hf: d.cyc = CYC_RM[m] + CYC_STORE_ADD; // RULE_04
						4'hc: d.cyc = CYC_RM[m] - CYC_JUMP_SUB; // RULE_05
						4'hd: d.cyc = CYC_RM[m] + CYC_CALL_ADD; // RULE_06
						default: ;
					endcase
				end
			end
		endcase
		return d;
	endfunction : decode

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic ack_q;
	logic [31:0] rdata_q;
	logic [7:0] acc_q, idx_q, opnd_q, res_q;
	logic [4:0] fl_q;
	logic [5:0] sp_q;
	logic [3:0] cnt_q;
	logic pend_q, taken_q, memw_q, take_q;
	cod_dec_type last_q;
	wire logic req = avs_read | avs_write;
	wire logic busy = (cnt_q != 4'h0);
	wire logic wr_op_addr = avs_write & (avs_address == REG_OPCODE);
	wire logic stall = wr_op_addr & busy;
	wire logic do_write = avs_write & ack_q & avs_byteenable[0];
	wire logic do_exec = do_write & (avs_address == REG_OPCODE);
	wire logic [7:0] op = avs_writedata[7:0];
	wire cod_dec_type dec = decode(op);
	wire logic take = pend_q & ~fl_q[FL_I] & ~busy & ~avs_write; // RULE_23
	wire logic [31:0] status = {21'h0, busy, pend_q, memw_q, taken_q, last_q.illegal,
		last_q.len, last_q.cyc};
	wire logic [31:0] rd_mux =
		(avs_address == REG_OPERAND) ? {24'h0, opnd_q} :
		(avs_address == REG_ACC) ? {24'h0, acc_q} :
		(avs_address == REG_INDEX) ? {24'h0, idx_q} :
		(avs_address == REG_FLAGS) ? {27'h0, fl_q} :
		(avs_address == REG_STACK) ? {26'h0, sp_q} :
		(avs_address == REG_RESULT) ? {24'h0, res_q} :
		(avs_address == REG_STATUS) ? status : 32'h0;

	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata = rdata_q;
	assign irq_ack = take_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= req & ~ack_q & ~stall;
			rdata_q <= avs_read ? rd_mux : 32'h0;
		end
	end

	// ----------------------------------------
	// Execution
	// ----------------------------------------
	logic [7:0] acc_d, idx_d, res_d, src, val, rg;
	logic [4:0] fl_d;
	logic [5:0] sp_d;
	logic [3:0] cnt_d;
	logic [8:0] sum;
	logic [4:0] hsum;
	logic taken_d, memw_d, nz_en, cin, brc;

	always_comb begin
		acc_d = acc_q;
		idx_d = idx_q;
		fl_d = fl_q;
		sp_d = sp_q;
		res_d = res_q;
		taken_d = taken_q;
		memw_d = memw_q;
		cnt_d = busy ? cnt_q - 4'h1 : 4'h0;
		val = 8'h0;
		sum = 9'h0;
		hsum = 5'h0;
		nz_en = 1'b0;
		cin = 1'b0;
		brc = 1'b0;
		src = (op[7:4] == 4'h4) ? acc_q : (op[7:4] == 4'h5) ? idx_q : opnd_q;
		rg = (op[3:0] inside {4'h3, 4'he, 4'hf}) ? idx_q : acc_q;
		if (do_exec) begin
			cnt_d = dec.cyc;
			taken_d = 1'b0;
			memw_d = 1'b0;
			case (dec.cls)
				CL_MUL: begin
					{idx_d, acc_d} = 16'(acc_q) * 16'(idx_q); // RULE_01
					fl_d[FL_H] = 1'b0; // RULE_01
					fl_d[FL_C] = 1'b0;
				end
				CL_BTB: begin
					fl_d[FL_C] = opnd_q[op[3:1]]; // RULE_12
					taken_d = opnd_q[op[3:1]] ^ op[0];
				end
				CL_BSC: begin
					res_d = opnd_q;
					res_d[op[3:1]] = ~op[0]; // RULE_13
					memw_d = 1'b1;
				end
				CL_REL: begin
					case (op[3:1])
						3'h0: brc = 1'b1;
						3'h1: brc = ~(fl_q[FL_C] | fl_q[FL_Z]);
						3'h2: brc = ~fl_q[FL_C];
						3'h3: brc = ~fl_q[FL_Z];
						3'h4: brc = ~fl_q[FL_H]; // RULE_10
						3'h5: brc = ~fl_q[FL_N];
						3'h6: brc = ~fl_q[FL_I]; // RULE_09
						default: brc = ~irq_line_level; // RULE_08
					endcase
					taken_d = brc ^ op[0]; // RULE_07
				end
				CL_RMW: begin
					nz_en = 1'b1; // RULE_21
					case (op[3:0])
						4'h0: begin
							val = 8'h0 - src;
							fl_d[FL_C] = (val != 8'h0);
						end
						4'h3: begin
							val = ~src;
							fl_d[FL_C] = 1'b1;
						end
						4'h4: begin
							val = {1'b0, src[7:1]};
							fl_d[FL_C] = src[0];
						end
						4'h6: begin
							val = {fl_q[FL_C], src[7:1]}; // RULE_16
							fl_d[FL_C] = src[0];
						end
						4'h7: begin
							val = {src[7], src[7:1]};
							fl_d[FL_C] = src[0];
						end
						4'h8: begin
							val = {src[6:0], 1'b0};
							fl_d[FL_C] = src[7];
						end
						4'h9: begin
							val = {src[6:0], fl_q[FL_C]}; // RULE_16
							fl_d[FL_C] = src[7];
						end
						4'ha: val = src - 8'h1;
						4'hc: val = src + 8'h1;
						4'hd: val = src;
						default: val = 8'h0;
					endcase
					if (op[3:0] != 4'hd) begin
						if (op[7:4] == 4'h4)
							acc_d = val;
						else if (op[7:4] == 4'h5)
							idx_d = val;
						else begin
							res_d = val;
							memw_d = 1'b1;
						end
					end
				end
				CL_CTL: begin
					case (op)
						OPC_TAX: idx_d = acc_q;
						OPC_TXA: acc_d = idx_q;
						OPC_CLC: fl_d[FL_C] = 1'b0;
						OPC_SEC: fl_d[FL_C] = 1'b1;
						OPC_CLI: fl_d[FL_I] = 1'b0;
						OPC_SEI: fl_d[FL_I] = 1'b1;
						OPC_RSP: sp_d = SP_RST;
						OPC_SWI: begin
							fl_d[FL_I] = 1'b1; // RULE_18
							sp_d = sp_q - PUSH_IRQ; // RULE_24
						end
						OPC_RTI: begin
							fl_d = opnd_q[4:0]; // RULE_19
							sp_d = sp_q + PUSH_IRQ;
						end
						OPC_RTS: sp_d = sp_q + PUSH_CALL;
						OPC_STOP, OPC_WAIT: fl_d[FL_I] = 1'b0; // RULE_20
						default: ;
					endcase
				end
				CL_RM: begin
					case (op[3:0])
						4'h0, 4'h1, 4'h2, 4'h3: begin
							cin = (op[3:0] == 4'h2) & fl_q[FL_C];
							sum = {1'b0, rg} - {1'b0, opnd_q} - {8'h0, cin};
							val = sum[7:0];
							fl_d[FL_C] = sum[8];
							nz_en = 1'b1;
							if (op[3:0] == 4'h0 || op[3:0] == 4'h2)
								acc_d = val;
						end
						4'h4, 4'h5, 4'h8, 4'ha: begin
							val = (op[3:0] == 4'h8) ? (rg ^ opnd_q) :
								(op[3:0] == 4'ha) ? (rg | opnd_q) : (rg & opnd_q);
							nz_en = 1'b1;
							if (op[3:0] != 4'h5)
								acc_d = val;
						end
						4'h6, 4'he: begin
							val = opnd_q;
							nz_en = 1'b1;
							if (op[3:0] == 4'h6)
								acc_d = val;
							else
								idx_d = val;
						end
						4'h7, 4'hf: begin
							val = rg;
							res_d = rg;
							memw_d = 1'b1;
							nz_en = 1'b1;
						end
						4'h9, 4'hb: begin
							cin = (op[3:0] == 4'h9) & fl_q[FL_C];
							sum = {1'b0, rg} + {1'b0, opnd_q} + {8'h0, cin};
							hsum = {1'b0, rg[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, cin};
							fl_d[FL_H] = hsum[4]; // RULE_22
							fl_d[FL_C] = sum[8];
							val = sum[7:0];
							nz_en = 1'b1;
							acc_d = val;
						end
						4'hd: sp_d = sp_q - PUSH_CALL; // RULE_24
						default: ;
					endcase
				end
				default: ; // RULE_25
			endcase
			if (nz_en) begin
				fl_d[FL_N] = val[7]; // RULE_21
				fl_d[FL_Z] = (val == 8'h0);
			end
		end else if (do_write) begin
			case (avs_address)
				REG_ACC: acc_d = op;
				REG_INDEX: idx_d = op;
				REG_FLAGS: fl_d = op[4:0];
				REG_STACK: sp_d = op[5:0];
				default: ;
			endcase
		end else if (take) begin
			fl_d[FL_I] = 1'b1;
			sp_d = sp_q - PUSH_IRQ; // RULE_24
			cnt_d = CYC_SWI;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{acc_q, idx_q, res_q, opnd_q} <= 32'h0;
			fl_q <= FLAGS_RST;
			sp_q <= SP_RST;
			{cnt_q, pend_q, taken_q, memw_q, take_q} <= 8'h0;
			last_q <= '{illegal: 1'b0, cls: CL_NONE, len: 2'h0, cyc: 4'h0};
		end else begin
			{acc_q, idx_q, res_q, fl_q, sp_q} <= {acc_d, idx_d, res_d, fl_d, sp_d};
			{cnt_q, taken_q, memw_q, take_q} <= {cnt_d, taken_d, memw_d, take};
			pend_q <= irq_request | (pend_q & ~take); // RULE_23
			if (do_write && avs_address == REG_OPERAND)
				opnd_q <= op;
			if (do_exec)
				last_q <= dec;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_exec(logic [7:0] code);
		do_exec && op == code;
	endsequence
	sequence s_busy_hold;
		busy [*8];
	endsequence

	property p_mul_value;
		s_exec(OPC_MUL) |=> {idx_q, acc_q} == 16'($past(acc_q)) * 16'($past(idx_q))
			&& !fl_q[FL_H] && !fl_q[FL_C];
	endproperty
	a_mul_value: assert property (p_mul_value) else $error("product wrong"); // RULE_01
	property p_mul_time;
		s_exec(OPC_MUL) |=> s_busy_hold ##3 busy ##1 !busy;
	endproperty
	a_mul_time: assert property (p_mul_time) else $error("product timing wrong"); // RULE_02
	property p_rel_size;
		do_exec && op[7:4] == 4'h2 |=> last_q.len == 2'h2 && cnt_q == 4'h3;
	endproperty
	a_rel_size: assert property (p_rel_size) else $error("branch size wrong"); // RULE_07
	property p_pin_branch;
		do_exec && op[7:1] == 7'h17 |=> taken_q == ($past(irq_line_level) ^ ~$past(op[0]));
	endproperty
	a_pin_branch: assert property (p_pin_branch) else $error("pin branch wrong"); // RULE_08
	property p_swi;
		s_exec(OPC_SWI) |=> fl_q[FL_I] && cnt_q == 4'ha && sp_q == $past(sp_q) - 6'h5;
	endproperty
	a_swi: assert property (p_swi) else $error("trap wrong"); // RULE_18
	property p_stop_wait;
		do_exec && (op == OPC_STOP || op == OPC_WAIT) |=> !fl_q[FL_I] && busy ##1 busy ##1 !busy;
	endproperty
	a_stop_wait: assert property (p_stop_wait) else $error("mask not cleared"); // RULE_20
	property p_nop_hold;
		s_exec(OPC_NOP) |=> $stable(fl_q) && $stable(acc_q) && $stable(idx_q);
	endproperty
	a_nop_hold: assert property (p_nop_hold) else $error("flags disturbed"); // RULE_21
	property p_pending;
		irq_request && fl_q[FL_I] && !take |=> pend_q;
	endproperty
	a_pending: assert property (p_pending) else $error("interrupt lost"); // RULE_23
	property p_call_push;
		s_exec(OPC_BSR) |=> sp_q == $past(sp_q) - 6'h2 && cnt_q == 4'h6;
	endproperty
	a_call_push: assert property (p_call_push) else $error("call push wrong"); // RULE_24
	property p_illegal;
		do_exec && dec.illegal |=> $stable(fl_q) && $stable(sp_q) && cnt_q == 4'h2;
	endproperty
	a_illegal: assert property (p_illegal) else $error("unassigned opcode acted"); // RULE_25
endmodule : cod_core

// ===== sim/cod_irq_src.sv
`timescale 1ns/100ps
module cod_irq_src (
	input wire logic ref_clk,
	input wire logic line_in,
	output logic irq_line_level,
	output logic irq_request
);
	initial irq_request = 1'b0;
	assign irq_line_level = line_in;
	// One-cycle maskable request
	task automatic pulse;
		@(posedge ref_clk);
		irq_request <= 1'b1;
		@(posedge ref_clk);
		irq_request <= 1'b0;
	endtask : pulse
endmodule : cod_irq_src

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	import cod_pkg::*;
	typedef struct packed {logic [31:0] v; logic [31:0] m;} cod_exp_type;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq_line_level;
	logic irq_request;
	logic irq_ack;
	logic line_q = 1'b0;
	int failures = 0;
	int check_count = 0;
	int ack_count = 0;
	cod_exp_type exp_q[$];
	logic [7:0] a;
	logic [7:0] v;
	logic [7:0] r;
	logic [15:0] p;
	logic c;
	// Entries: illegal, opcode, length, cycles
	logic [19:0] tbl [0:52] = '{20'h0421b,
		20'h0a622, 20'h0b623, 20'h0c634, 20'h0f613, 20'h0e624, 20'h0d635,
		20'h0b724, 20'h0c735, 20'h0f714, 20'h0e725, 20'h0d736, 20'h0bc22,
		20'h0cc33, 20'h0fc12, 20'h0ec23, 20'h0dc34, 20'h0bd25, 20'h0cd36,
		20'h0fd15, 20'h0ed26, 20'h0dd37, 20'h02023, 20'h02f23, 20'h0ad26,
		20'h00e35, 20'h00f35, 20'h01e25, 20'h01f25, 20'h04c13, 20'h05c13,
		20'h03c25, 20'h07c15, 20'h06c26, 20'h04d13, 20'h03d24, 20'h07d14,
		20'h06d25, 20'h09712, 20'h09f12, 20'h09912, 20'h09812, 20'h09b12,
		20'h09a12, 20'h09c12, 20'h09d12, 20'h0831a, 20'h08019, 20'h08116,
		20'h08e12, 20'h08f12, 20'h1a712, 20'h14112};

	always #50 ref_clk = ~ref_clk;

	cod_core i_cod_core (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq_line_level(irq_line_level),
		.irq_request(irq_request), .irq_ack(irq_ack));

	cod_irq_src i_cod_irq_src (.ref_clk(ref_clk), .line_in(line_q),
		.irq_line_level(irq_line_level), .irq_request(irq_request));

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask : check

	task automatic close_out;
		if (failures == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	always @(negedge ref_clk) begin : mon
		cod_exp_type e;
		if (irq_ack === 1'b1) begin
			ack_count++;
		end
		if (avs_read && avs_waitrequest === 1'b0) begin
			e = exp_q.pop_front();
			check(avs_readdata & e.m, e.v & e.m);
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		close_out();
	end

	// ----------------------------------------
	// Bus access
	// ----------------------------------------
	task automatic bus(input logic wr_en, input logic [7:0] adr, input logic [7:0] dat);
		logic w;
		@(posedge ref_clk);
		avs_address <= adr;
		avs_writedata <= {24'h0, dat};
		avs_write <= wr_en;
		avs_read <= ~wr_en;
		do begin
			@(negedge ref_clk);
			w = avs_waitrequest;
			@(posedge ref_clk);
		end while (w !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] adr, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back({e, m});
		bus(1'b0, adr, 8'h00);
	endtask : rd

	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		bus(1'b1, adr, d);
	endtask : wr

	task automatic ex(input logic [7:0] op);
		wr(REG_OPCODE, op);
	endtask : ex

	task automatic run(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			ex(tbl[i][15:8]);
			rd(REG_STATUS, {25'h0, tbl[i][16], tbl[i][5:4], tbl[i][3:0]}, 32'h7f);
		end
	endtask : run

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(32'h20a1dd64));
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(REG_STACK, 32'h3f, 32'hffffffff);
		rd(8'h20, 32'h0, 32'hffffffff);
		wr(REG_ACC, 8'h5a);
		avs_byteenable <= 4'he;
		wr(REG_ACC, 8'ha5);
		avs_byteenable <= 4'h1;
		rd(REG_ACC, 32'h5a, 32'hffffffff);
		run(0, 0);
		run(1, 6);
		run(7, 11);
		run(12, 16);
		run(17, 21);
		run(22, 24);
		run(25, 28);
		run(29, 37);
		run(38, 45);
		run(46, 50);
		run(51, 52);
		a = 8'($urandom);
		v = 8'($urandom);
		p = {8'h0, a} * {8'h0, v};
		wr(REG_ACC, a);
		wr(REG_INDEX, v);
		wr(REG_FLAGS, 8'h1f);
		ex(OPC_MUL);
		rd(REG_ACC, {24'h0, p[7:0]}, 32'hff);
		rd(REG_INDEX, {24'h0, p[15:8]}, 32'hff);
		rd(REG_FLAGS, 32'h0e, 32'h1f);
		for (int k = 0; k < 2; k++) begin
			a = 8'($urandom);
			c = 1'($urandom);
			wr(REG_ACC, a);
			wr(REG_FLAGS, {4'h0, 1'b1, 2'h0, c});
			ex(k ? 8'h46 : 8'h49);
			r = k ? {c, a[7:1]} : {a[6:0], c};
			rd(REG_ACC, {24'h0, r}, 32'hff);
			rd(REG_FLAGS, {28'h1, r[7], r == 8'h0, k ? a[0] : a[7]}, 32'h1f);
		end
		wr(REG_ACC, 8'h0f);
		wr(REG_OPERAND, 8'h01);
		wr(REG_FLAGS, 8'h08);
		ex(8'hab);
		rd(REG_ACC, 32'h10, 32'hff);
		rd(REG_FLAGS, 32'h18, 32'h1f);
		for (int n = 0; n < 8; n++) begin
			v = 8'($urandom);
			wr(REG_OPERAND, v);
			ex({4'h0, 3'(n), 1'b0});
			rd(REG_STATUS, {24'h0, v[n], 7'h0}, 32'h80);
			rd(REG_FLAGS, {31'h0, v[n]}, 32'h01);
			ex({4'h0, 3'(n), 1'b1});
			rd(REG_STATUS, {24'h0, ~v[n], 7'h0}, 32'h80);
			ex({4'h1, 3'(n), 1'b0});
			rd(REG_RESULT, {24'h0, v | (8'h01 << n)}, 32'hff);
			ex({4'h1, 3'(n), 1'b1});
			rd(REG_RESULT, {24'h0, v & ~(8'h01 << n)}, 32'hff);
		end
		ex(8'h3c);
		rd(REG_RESULT, {24'h0, v + 8'h01}, 32'hff);
		rd(REG_STATUS, 32'h100, 32'h100);
		ex(8'h3d);
		rd(REG_STATUS, 32'h0, 32'h100);
		for (int f = 0; f < 2; f++) begin
			line_q <= f[0];
			wr(REG_FLAGS, f[0] ? 8'h1c : 8'h00);
			for (int j = 0; j < 8; j++) begin
				ex(8'h28 + 8'(j));
				rd(REG_STATUS, {24'h0, f[0] ^ ~j[0], 7'h0}, 32'h80);
			end
		end
		a = 8'($urandom);
		wr(REG_ACC, a);
		ex(OPC_TAX);
		rd(REG_INDEX, {24'h0, a}, 32'hff);
		wr(REG_INDEX, ~a);
		ex(OPC_TXA);
		rd(REG_ACC, {24'h0, ~a}, 32'hff);
		wr(REG_FLAGS, 8'h00);
		ex(OPC_SEC);
		ex(OPC_SEI);
		rd(REG_FLAGS, 32'h09, 32'h1f);
		ex(OPC_CLC);
		ex(OPC_CLI);
		rd(REG_FLAGS, 32'h00, 32'h1f);
		wr(REG_STACK, 8'h05);
		ex(OPC_RSP);
		rd(REG_STACK, 32'h3f, 32'h3f);
		wr(REG_STACK, 8'h01);
		ex(OPC_BSR);
		rd(REG_STACK, 32'h3f, 32'h3f);
		ex(OPC_RTS);
		rd(REG_STACK, 32'h01, 32'h3f);
		ex(OPC_SWI);
		rd(REG_STACK, 32'h3c, 32'h3f);
		rd(REG_FLAGS, 32'h08, 32'h08);
		wr(REG_OPERAND, 8'h15);
		ex(OPC_RTI);
		rd(REG_FLAGS, 32'h15, 32'h1f);
		rd(REG_STACK, 32'h01, 32'h3f);
		for (int k = 0; k < 2; k++) begin
			wr(REG_FLAGS, 8'h1f);
			ex(k ? OPC_WAIT : OPC_STOP);
			rd(REG_FLAGS, 32'h17, 32'h1f);
		end
		wr(REG_FLAGS, 8'h08);
		wr(REG_STACK, 8'h3f);
		i_cod_irq_src.pulse();
		rd(REG_STATUS, 32'h200, 32'h200);
		rd(REG_FLAGS, 32'h08, 32'h1f);
		check(32'(ack_count), 32'h0);
		wr(REG_FLAGS, 8'h00);
		for (int t = 0; t < 40 && ack_count == 0; t++) @(posedge ref_clk);
		check(32'(ack_count), 32'h1);
		rd(REG_FLAGS, 32'h08, 32'h08);
		rd(REG_STACK, 32'h3a, 32'h3f);
		rd(REG_STATUS, 32'h0, 32'h200);
		check(32'(exp_q.size()), 32'h0);
		close_out();
	end
endmodule : testbench
